// File: hdl/lrt_cfg.svh
`ifndef LRT_CFG_SVH
`define LRT_CFG_SVH
`define LRT_CNT_W 8
`define LRT_MODE_W 5
`define LRT_MODE_LOW_RST 5'h0e
`define LRT_MODE_HIGH_RST 5'h0f
`define LRT_MODE_LVL_BIT 0
`define LRT_CNT_START 8'h00
`define LRT_CNT_STEP 8'h01
`endif

// File: hdl/lrt_pkg.sv
`include "lrt_cfg.svh"
package lrt_pkg;
   typedef logic [`LRT_CNT_W-1:0] lrt_cnt_t;
   typedef enum logic [2:0]
   {
      LRT_IDLE = 3'h1,
      LRT_ARMED = 3'h2,
      LRT_COUNT = 3'h4
   } lrt_state_t;
endpackage : lrt_pkg

// File: hdl/lrt_sync.sv
module lrt_sync
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed
   {
      logic meta;
      logic held;
   } lrt_sync_regs_t;

   lrt_sync_regs_t r;
   lrt_sync_regs_t next_r;

   // only the second stage leaves: the first may still be settling
   always_comb
   begin
      next_r.meta = d_i;
      next_r.held = r.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r <= '0;
      else
         r <= next_r;
   end

   assign q_o = r.held;
endmodule : lrt_sync

// File: hdl/lrt_timer.sv
// What this block does
// - in the low-reset mode the count is held at start while ext is low.
// - in the high-reset mode the count is held at start while ext is high.
// - the hold follows the level of ext, not its edges.
// - counting starts on a reset-to-active edge of ext while run is set.
// - a period match returns the count to start and clears run, unless run_set_i is high in that cycle.
// - once run clears, a restart needs run set and then a fresh edge.
// - the pwm output asserts on the edge that starts the count.
// - the pwm output deasserts on the step after the count equals the pulse width value.
// - at the period match the pwm stays low until the next starting edge.
`include "lrt_cfg.svh"
module lrt_timer
   import lrt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`LRT_MODE_W-1:0] mode_i,
   input wire logic run_set_i,
   input wire logic run_clr_i,
   input wire logic ext_i,
   input wire logic [`LRT_CNT_W-1:0] period_match_value_i,
   input wire logic [`LRT_CNT_W-1:0] pulse_width_value_i,
   output logic run_o,
   output logic [`LRT_CNT_W-1:0] count_o,
   output logic pwm_o,
   output logic active_o
);
   // ------------------------------------------------------------
   // external signal, synchronised
   // ------------------------------------------------------------
   logic ext_s;
   lrt_sync u_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(ext_i),
      .q_o(ext_s)
   );

   typedef struct packed
   {
      lrt_state_t state;
      logic run;
      lrt_cnt_t cnt;
      logic pwm;
      logic ext_d;
      logic active;
   } lrt_regs_t;

   lrt_regs_t r;
   lrt_regs_t next_r;
   logic mode_ok;
   logic in_reset;
   logic start_edge;
   logic rst_lvl;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      mode_ok = (mode_i == `LRT_MODE_LOW_RST) ||
         (mode_i == `LRT_MODE_HIGH_RST);
      // reset level equals mode lsb: 0 low, 1 high
      rst_lvl = mode_i[`LRT_MODE_LVL_BIT];
      in_reset = mode_ok && (ext_s == rst_lvl);
      start_edge = mode_ok && !in_reset && (r.ext_d == rst_lvl);
      next_r.ext_d = ext_s;
      // set wins over a simultaneous software clear
      if (run_set_i)
         next_r.run = 1'b1;
      else if (run_clr_i)
         next_r.run = 1'b0;
      case (r.state)
         LRT_IDLE:
         begin
            next_r.pwm = 1'b0;
            // a fresh edge is only honoured once run is seen set
            if (r.run)
               next_r.state = LRT_ARMED;
         end
         LRT_ARMED:
         begin
            if (!r.run)
               next_r.state = LRT_IDLE;
            else if (start_edge)
            begin
               next_r.state = LRT_COUNT;
               next_r.pwm = 1'b1;
            end
         end
         LRT_COUNT:
         begin
            if (!r.run)
            begin
               // leaving early must not leave the drive high
               next_r.state = LRT_IDLE;
               next_r.pwm = 1'b0;
            end
            else if (r.cnt == period_match_value_i)
            begin
               next_r.cnt = `LRT_CNT_START;
               next_r.run = run_set_i;
               next_r.pwm = 1'b0;
               next_r.state = LRT_IDLE;
            end
            else
            begin
               next_r.cnt = r.cnt + `LRT_CNT_STEP;
               if (r.cnt == pulse_width_value_i)
                  next_r.pwm = 1'b0;
            end
         end
         default:
            next_r.state = LRT_IDLE;
      endcase
      if (in_reset)
      begin
         next_r.cnt = `LRT_CNT_START;
         next_r.pwm = 1'b0;
         // a shot that ended this cycle stays ended
         if (next_r.state == LRT_COUNT)
            next_r.state = LRT_ARMED;
      end
      // decoded here so that the output leaves a flop
      next_r.active = (next_r.state == LRT_COUNT);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r.state <= LRT_IDLE;
         r.run <= 1'b0;
         r.cnt <= `LRT_CNT_START;
         r.pwm <= 1'b0;
         r.ext_d <= 1'b0;
         r.active <= 1'b0;
      end
      else
         r <= next_r;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign run_o = r.run;
   assign count_o = r.cnt;
   assign pwm_o = r.pwm;
   assign active_o = r.active;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_reset_out: assert property (
      @(posedge clk_i)
      rst_i |=> (!run_o && !pwm_o && !active_o
      && count_o == `LRT_CNT_START))
      else $error("outputs not cleared by reset");

   a_hold_low: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (mode_i == `LRT_MODE_LOW_RST && !ext_s)
      |=> count_o == `LRT_CNT_START)
      else $error("count not held in low reset");

   a_hold_high: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (mode_i == `LRT_MODE_HIGH_RST && ext_s)
      |=> count_o == `LRT_CNT_START)
      else $error("count not held in high reset");

   a_level_hold: assert property (
      @(posedge clk_i) disable iff (rst_i)
      in_reset |=> !active_o)
      else $error("running while reset level held");

   a_start_edge: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (r.state == LRT_ARMED && run_o && start_edge)
      |=> active_o && pwm_o)
      else $error("edge did not start count");

   a_period_end: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (active_o && run_o && !in_reset && !run_set_i
      && count_o == period_match_value_i)
      |=> !run_o && count_o == `LRT_CNT_START)
      else $error("period match did not end shot");

   a_no_restart: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(run_o) |=> !active_o [*2])
      else $error("restart without new arming");

   a_idle_wait: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (r.state == LRT_IDLE) |=> !active_o)
      else $error("count started straight from idle");

   a_pwm_rise: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(pwm_o) |-> $rose(active_o))
      else $error("pwm rose off the start edge");

   a_pwm_fall: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (active_o && run_o && count_o == pulse_width_value_i) |=> !pwm_o)
      else $error("pwm not cleared at width");

   a_pwm_idle: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !active_o |-> !pwm_o)
      else $error("pwm high while not counting");

   a_count_step: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (active_o && run_o && !in_reset && !run_clr_i
      && count_o != period_match_value_i)
      |=> count_o == $past(count_o) + `LRT_CNT_STEP)
      else $error("count did not step");

   a_hold_stop: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!run_o && !in_reset) |=> $stable(count_o))
      else $error("count moved with run clear");
endmodule : lrt_timer

// File: sim/lrt_ext_src.sv
module lrt_ext_src
(
   input wire logic clk_i,
   input wire logic lvl_i,
   output logic ext_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // moves 3 ns after each rising clock edge, between sampling edges
   always @(posedge clk_i)
      ext_o <= #3 lvl_i;
endmodule : lrt_ext_src

// File: sim/tb.sv
`include "lrt_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, run_set_i, run_clr_i, lvl, ext_i;
   logic run_o, pwm_o, active_o;
   logic [`LRT_MODE_W-1:0] mode_i;
   logic [`LRT_CNT_W-1:0] per, pw, count_o;
   int num_errors = 0;
   int compares = 0;
   lrt_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
      .run_set_i(run_set_i), .run_clr_i(run_clr_i), .ext_i(ext_i),
      .period_match_value_i(per), .pulse_width_value_i(pw),
      .run_o(run_o), .count_o(count_o), .pwm_o(pwm_o),
      .active_o(active_o));
   lrt_ext_src src_u (.clk_i(clk_i), .lvl_i(lvl), .ext_o(ext_i));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task results;
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   task start;
      int n;
      for (n = 0; n < 12 && active_o !== 1'b1; n++)
         tick(1);
      if (n == 12)
      begin
         num_errors++;
         results();
      end
   endtask : start
   task arm(input logic [4:0] m, input logic l);
      @(posedge clk_i);
      mode_i <= m;
      lvl <= l;
      run_set_i <= 1'b1;
      @(posedge clk_i);
      run_set_i <= 1'b0;
      tick(4);
   endtask : arm
   task edge_to(input logic l);
      @(posedge clk_i);
      lvl <= l;
   endtask : edge_to
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_low;
      arm(`LRT_MODE_LOW_RST, 1'b0);
      edge_to(1'b1);
      start();
      chk({pwm_o, count_o}, 16'h0100);
      for (int i = 1; i <= 6; i++)
      begin
         tick(1);
         chk({pwm_o, count_o}, {7'h0, i <= 3, i[7:0]});
      end
      tick(1);
      chk({run_o, active_o, pwm_o, count_o}, 16'h0);
      tick(3);
      chk({run_o, pwm_o, count_o}, 16'h0);
      arm(`LRT_MODE_LOW_RST, 1'b1);
      chk({run_o, active_o}, 16'h2);
      edge_to(1'b0);
      edge_to(1'b1);
      start();
      tick(2);
      chk(count_o, 16'h2);
      edge_to(1'b0);
      tick(5);
      chk({active_o, pwm_o, count_o}, 16'h0);
      tick(3);
      chk({active_o, count_o}, 16'h0);
      $display("low reset level test done");
   endtask : t_low
   task t_high;
      @(posedge clk_i);
      per <= 8'h09;
      arm(`LRT_MODE_HIGH_RST, 1'b1);
      edge_to(1'b0);
      start();
      tick(2);
      chk(count_o, 16'h2);
      edge_to(1'b1);
      tick(5);
      chk({pwm_o, count_o}, 16'h0);
      edge_to(1'b0);
      start();
      @(posedge clk_i);
      run_clr_i <= 1'b1;
      @(posedge clk_i);
      run_clr_i <= 1'b0;
      tick(3);
      chk({run_o, pwm_o}, 16'h0);
      $display("high reset level test done");
   endtask : t_high
   task t_other;
      arm(`LRT_MODE_HIGH_RST, 1'b1);
      edge_to(1'b0);
      start();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(1);
      chk({run_o, active_o, pwm_o, count_o}, 16'h0);
      // ext already at active level: no false edge after reset
      arm(`LRT_MODE_HIGH_RST, 1'b0);
      tick(4);
      chk({run_o, active_o, count_o}, 16'h200);
      // a code outside the two modes never starts the count
      arm(5'h00, 1'b1);
      edge_to(1'b0);
      tick(5);
      chk({active_o, pwm_o, count_o}, 16'h0);
      $display("reset and other mode test done");
   endtask : t_other
   initial
   begin
      rst_i = 1'b1;
      mode_i = '0;
      run_set_i = 1'b0;
      run_clr_i = 1'b0;
      lvl = 1'b0;
      per = 8'h06;
      pw = 8'h03;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_low();
      t_high();
      t_other();
      results();
   end
endmodule : tb
